// File: rtl/adc_cal_consts.vh
// Constants for the converter calibration back end and its register map
`ifndef ADC_CAL_CONSTS_VH
`define ADC_CAL_CONSTS_VH

`define A_REF_CTRL      8'h00
`define A_EXCITE        8'h04
`define A_BURNOUT       8'h08
`define A_BIAS          8'h0c
`define A_MUX           8'h10
`define A_GAIN          8'h14
`define A_GPIO_CFG      8'h18
`define A_GPIO_DIR      8'h1c
`define A_GPIO_DATA     8'h20
`define A_OFS0          8'h24
`define A_OFS1          8'h28
`define A_OFS2          8'h2c
`define A_GC0           8'h30
`define A_GC1           8'h34
`define A_GC2           8'h38
`define A_RESULT        8'h3c
`define A_STATUS        8'h40

`define OFS_RESET       24'h000000
`define GC_RESET        24'h400000
`define GC_SHIFT        22
`define MON_NONE        3'h0
`define MON_TEMP        3'h1
`define MON_AVDD        3'h2
`define MON_DVDD        3'h3
`define MON_EXTREF      3'h4
`define GAIN_UNITY      3'h0
`define ROUTE_OFF       4'hf
`define CAL_OFFSET      1'b0
`define CAL_GAIN        1'b1
`define ST_EXT_CLK      0
`define ST_NEW_RESULT   1

`endif

// File: rtl/clock_source_latch.v
// Clock source selection latch: internal oscillator until external activity
`timescale 1ns/1ps
module clock_source_latch (
    input  wire ref_clk_i,
    input  wire nrst_i,
    input  wire ext_clk_pin_i,
    output reg  ext_sel_o
);
    reg pin_d_r;

    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            // Track the pin in reset so a static level gives no false edge
            pin_d_r   <= ext_clk_pin_i;
            ext_sel_o <= 1'b0;
        end
        else
        begin
            pin_d_r <= ext_clk_pin_i;
            // Any transition counts as a clock; a pin tied low never toggles
            if (pin_d_r != ext_clk_pin_i)
                ext_sel_o <= 1'b1;
            // No clear path besides reset
        end
    end
endmodule // clock_source_latch

// File: rtl/cal_datapath.v
// Offset subtraction, gain scaling and saturation of the filter output
`timescale 1ns/1ps
`include "adc_cal_consts.vh"
module cal_datapath (
    input  wire        ref_clk_i,
    input  wire        nrst_i,
    input  wire        in_valid_i,
    input  wire [23:0] in_data_i,
    input  wire [23:0] offset_i,
    input  wire [23:0] gain_i,
    output reg         out_valid_o,
    output reg  [23:0] out_data_o
);
    wire signed [24:0] diff;
    wire signed [49:0] prod;
    wire               fits;

    // Zero offset passes the input through untouched
    assign diff = $signed({in_data_i[23], in_data_i})
                - $signed({offset_i[23], offset_i});
    // Gain is unsigned, so a zero sign bit is prepended
    assign prod = diff * $signed({1'b0, gain_i});
    assign fits = (prod[49:45] == {5{prod[45]}});

    always @(posedge ref_clk_i)
    begin
        if (!nrst_i)
        begin
            out_valid_o <= 1'b0;
            out_data_o  <= 24'h000000;
        end
        else
        begin
            out_valid_o <= in_valid_i;
            if (in_valid_i)
            begin
                if (fits)
                    out_data_o <= prod[45:`GC_SHIFT];
                else if (prod[49])
                    out_data_o <= 24'h800000;
                else
                    out_data_o <= 24'h7fffff;
            end
        end
    end
endmodule // cal_datapath

// File: rtl/adc_output_calibration.v
// Converter back end top: AHB-Lite registers, analog controls, calibration
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "adc_cal_consts.vh"
module adc_output_calibration (
    input  wire        REF_CLK_I,
    input  wire        NRST_I,
    // AHB-Lite slave
    input  wire        HSEL_I,
    input  wire [31:0] HADDR_I,
    input  wire [1:0]  HTRANS_I,
    input  wire        HWRITE_I,
    input  wire [2:0]  HSIZE_I,
    input  wire [31:0] HWDATA_I,
    input  wire        HREADY_I,
    output wire [31:0] HRDATA_O,
    output wire        HREADYOUT_O,
    output wire        HRESP_O,
    // Clock pin
    input  wire        EXT_CLK_PIN_I,
    output wire        CLK_SEL_EXT_O,
    // Filter result and calibration engine
    input  wire        FILT_VALID_I,
    input  wire [23:0] FILT_DATA_I,
    input  wire        CAL_DONE_I,
    input  wire        CAL_TARGET_I,
    input  wire [23:0] CAL_VALUE_I,
    output wire        RESULT_VALID_O,
    output wire [23:0] RESULT_O,
    // Analog controls
    output wire        REF_ON_O,
    output wire [1:0]  REF_SELECT_O,
    output wire [2:0]  EXCITE_A_LEVEL_O,
    output wire [2:0]  EXCITE_B_LEVEL_O,
    output wire [3:0]  EXCITE_A_ROUTE_O,
    output wire [3:0]  EXCITE_B_ROUTE_O,
    output wire        BURNOUT_ON_O,
    output wire [1:0]  BURNOUT_LEVEL_O,
    output wire [7:0]  BIAS_EN_O,
    output wire [2:0]  MUX_POS_O,
    output wire [2:0]  MUX_NEG_O,
    output wire [2:0]  MONITOR_SEL_O,
    output wire        ANALOG_CONNECT_O,
    output wire        ATTEN_QUARTER_O,
    output wire [2:0]  INPUT_AMPLIFIER_GAIN_O,
    // Dual-purpose pins
    input  wire [7:0]  GPIO_I,
    output wire [7:0]  GPIO_O,
    output wire [7:0]  GPIO_OE_O,
    output wire [7:0]  ANALOG_PIN_EN_O
);
    // Bus state
    reg        hready_r;
    reg [31:0] hrdata_r;
    reg        wr_pend_r;
    reg        rd_pend_r;
    reg [7:0]  addr_r;

    // Software registers
    reg        ref_on_r;
    reg [1:0]  ref_sel_r;
    reg [2:0]  exc_a_lvl_r;
    reg [2:0]  exc_b_lvl_r;
    reg [3:0]  exc_a_rt_r;
    reg [3:0]  exc_b_rt_r;
    reg [1:0]  burn_r;
    reg        burn_on_r;
    reg [7:0]  bias_r;
    reg [2:0]  mux_pos_r;
    reg [2:0]  mux_neg_r;
    reg [2:0]  mon_r;
    reg [2:0]  gain_r;
    reg [7:0]  gpio_cfg_r;
    reg [7:0]  gpio_dir_r;
    reg [7:0]  gpio_out_r;
    reg [23:0] offset_correction_r;
    reg [23:0] gain_correction_r;
    reg        new_res_r;

    // Registered pin drives
    reg        ref_on_o_r;
    reg [2:0]  exc_a_o_r;
    reg [2:0]  exc_b_o_r;
    reg        analog_conn_r;
    reg        atten_r;
    reg [2:0]  amp_gain_r;
    reg [7:0]  gpio_oe_r;
    reg [7:0]  gpio_o_r;
    reg [7:0]  ana_en_r;

    reg [31:0] rd_nxt;
    wire       addr_ok;
    wire       ext_sel;
    wire       res_valid;
    wire [23:0] res_data;
    wire       wr_hit;
    wire       rd_res;

    assign addr_ok  = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign wr_hit   = wr_pend_r;
    assign rd_res   = rd_pend_r & ~hready_r & (addr_r == `A_RESULT);

    always @(posedge REF_CLK_I)
    begin
        if (!NRST_I)
        begin
            hready_r  <= 1'b1;
            hrdata_r  <= 32'h00000000;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            wr_pend_r <= 1'b0;
            if (rd_pend_r)
            begin
                // Second data-phase cycle: data now reflects any earlier write
                hrdata_r  <= rd_nxt;
                hready_r  <= 1'b1;
                rd_pend_r <= 1'b0;
            end
            else if (addr_ok)
            begin
                addr_r    <= {HADDR_I[7:2], 2'b00};
                wr_pend_r <= HWRITE_I;
                rd_pend_r <= ~HWRITE_I;
                hready_r  <= HWRITE_I;
            end
        end
    end

    // Unmapped offsets read zero and ignore writes
    always @*
    begin
        rd_nxt = 32'h00000000;
        case (addr_r)
            `A_REF_CTRL:  rd_nxt = {29'h0, ref_sel_r, ref_on_r};
            `A_EXCITE:    rd_nxt = {17'h0, exc_b_rt_r, exc_a_rt_r, exc_b_lvl_r,
                                    1'b0, exc_a_lvl_r};
            `A_BURNOUT:   rd_nxt = {30'h0, burn_r};
            `A_BIAS:      rd_nxt = {24'h0, bias_r};
            `A_MUX:       rd_nxt = {21'h0, mon_r, 2'b00, mux_neg_r, mux_pos_r};
            `A_GAIN:      rd_nxt = {29'h0, gain_r};
            `A_GPIO_CFG:  rd_nxt = {24'h0, gpio_cfg_r};
            `A_GPIO_DIR:  rd_nxt = {24'h0, gpio_dir_r};
            `A_GPIO_DATA: rd_nxt = {24'h0, GPIO_I};
            `A_OFS0:      rd_nxt = {24'h0, offset_correction_r[7:0]};
            `A_OFS1:      rd_nxt = {24'h0, offset_correction_r[15:8]};
            `A_OFS2:      rd_nxt = {24'h0, offset_correction_r[23:16]};
            `A_GC0:       rd_nxt = {24'h0, gain_correction_r[7:0]};
            `A_GC1:       rd_nxt = {24'h0, gain_correction_r[15:8]};
            `A_GC2:       rd_nxt = {24'h0, gain_correction_r[23:16]};
            `A_RESULT:    rd_nxt = {8'h00, res_data};
            `A_STATUS:    rd_nxt = {30'h0, new_res_r, ext_sel};
            default:      rd_nxt = 32'h00000000;
        endcase
    end

    always @(posedge REF_CLK_I)
    begin
        if (!NRST_I)
        begin
            ref_on_r    <= 1'b0;
            ref_sel_r   <= 2'b00;
            exc_a_lvl_r <= 3'h0;
            exc_b_lvl_r <= 3'h0;
            exc_a_rt_r  <= `ROUTE_OFF;
            exc_b_rt_r  <= `ROUTE_OFF;
            burn_r      <= 2'b00;
            burn_on_r   <= 1'b0;
            bias_r      <= 8'h00;
            mux_pos_r   <= 3'h0;
            mux_neg_r   <= 3'h1;
            mon_r       <= `MON_NONE;
            gain_r      <= `GAIN_UNITY;
            gpio_cfg_r  <= 8'h00;
            gpio_dir_r  <= 8'h00;
            gpio_out_r  <= 8'h00;
        end
        else if (wr_hit)
        begin
            case (addr_r)
                `A_REF_CTRL:
                begin
                    ref_on_r  <= HWDATA_I[0];
                    ref_sel_r <= HWDATA_I[2:1];
                end
                `A_EXCITE:
                begin
                    // Levels 1..7: 50,100,250,500,750,1000,1500 uA; 0 is off
                    exc_a_lvl_r <= HWDATA_I[2:0];
                    exc_b_lvl_r <= HWDATA_I[6:4];
                    // 0..7 analog inputs, 8/9 current pins; equal codes allowed
                    exc_a_rt_r  <= HWDATA_I[11:8];
                    exc_b_rt_r  <= HWDATA_I[15:12];
                end
                `A_BURNOUT:
                begin
                    burn_r    <= HWDATA_I[1:0];
                    // Code 0 is off, 1..3 pick the three burnout magnitudes
                    burn_on_r <= |HWDATA_I[1:0];
                end
                `A_BIAS:      bias_r     <= HWDATA_I[7:0];
                `A_MUX:
                begin
                    mux_pos_r <= HWDATA_I[2:0];
                    mux_neg_r <= HWDATA_I[5:3];
                    mon_r     <= HWDATA_I[10:8];
                end
                `A_GAIN:      gain_r     <= HWDATA_I[2:0];
                `A_GPIO_CFG:  gpio_cfg_r <= HWDATA_I[7:0];
                `A_GPIO_DIR:  gpio_dir_r <= HWDATA_I[7:0];
                `A_GPIO_DATA: gpio_out_r <= HWDATA_I[7:0];
                default:      gpio_out_r <= gpio_out_r;
            endcase
        end
    end

    // Calibration completion overrides a host write to the register it targets landing in the same cycle
    always @(posedge REF_CLK_I)
    begin
        if (!NRST_I)
        begin
            offset_correction_r <= `OFS_RESET;
            gain_correction_r   <= `GC_RESET;
        end
        else
        begin
            if (CAL_DONE_I && CAL_TARGET_I == `CAL_OFFSET)
                offset_correction_r <= CAL_VALUE_I;
            else if (wr_hit && addr_r == `A_OFS0)
                offset_correction_r[7:0] <= HWDATA_I[7:0];
            else if (wr_hit && addr_r == `A_OFS1)
                offset_correction_r[15:8] <= HWDATA_I[7:0];
            else if (wr_hit && addr_r == `A_OFS2)
                offset_correction_r[23:16] <= HWDATA_I[7:0];
            if (CAL_DONE_I && CAL_TARGET_I == `CAL_GAIN)
                gain_correction_r <= CAL_VALUE_I;
            else if (wr_hit && addr_r == `A_GC0)
                gain_correction_r[7:0] <= HWDATA_I[7:0];
            else if (wr_hit && addr_r == `A_GC1)
                gain_correction_r[15:8] <= HWDATA_I[7:0];
            else if (wr_hit && addr_r == `A_GC2)
                gain_correction_r[23:16] <= HWDATA_I[7:0];
        end
    end

    // New-result flag: set wins over the clear by a result read
    always @(posedge REF_CLK_I)
    begin
        if (!NRST_I)
            new_res_r <= 1'b0;
        else if (res_valid)
            new_res_r <= 1'b1;
        else if (rd_res)
            new_res_r <= 1'b0;
    end

    // Pin drives, one cycle behind the registers
    always @(posedge REF_CLK_I)
    begin
        if (!NRST_I)
        begin
            ref_on_o_r    <= 1'b0;
            exc_a_o_r     <= 3'h0;
            exc_b_o_r     <= 3'h0;
            analog_conn_r <= 1'b1;
            atten_r       <= 1'b0;
            amp_gain_r    <= `GAIN_UNITY;
            gpio_oe_r     <= 8'h00;
            gpio_o_r      <= 8'h00;
            ana_en_r      <= 8'hff;
        end
        else
        begin
            ref_on_o_r    <= ref_on_r;
            // Sources draw their current from the reference, so keep them off
            exc_a_o_r     <= ref_on_r ? exc_a_lvl_r : 3'h0;
            exc_b_o_r     <= ref_on_r ? exc_b_lvl_r : 3'h0;
            analog_conn_r <= (mon_r == `MON_NONE);
            atten_r       <= (mon_r == `MON_AVDD) || (mon_r == `MON_DVDD)
                          || (mon_r == `MON_EXTREF);
            // Stored gain is not touched, so it returns after deselection
            amp_gain_r    <= (mon_r == `MON_TEMP) ? `GAIN_UNITY : gain_r;
            gpio_oe_r     <= gpio_cfg_r & gpio_dir_r;
            gpio_o_r      <= gpio_out_r & gpio_cfg_r;
            ana_en_r      <= ~gpio_cfg_r;
        end
    end

    clock_source_latch u_clk_sel (
        .ref_clk_i     (REF_CLK_I),
        .nrst_i        (NRST_I),
        .ext_clk_pin_i (EXT_CLK_PIN_I),
        .ext_sel_o     (ext_sel)
    );

    cal_datapath u_cal (
        .ref_clk_i   (REF_CLK_I),
        .nrst_i      (NRST_I),
        .in_valid_i  (FILT_VALID_I),
        .in_data_i   (FILT_DATA_I),
        .offset_i    (offset_correction_r),
        .gain_i      (gain_correction_r),
        .out_valid_o (res_valid),
        .out_data_o  (res_data)
    );

    reg hresp_r;
    always @(posedge REF_CLK_I)
    begin
        hresp_r <= 1'b0;
    end

    assign HRDATA_O               = hrdata_r;
    assign HREADYOUT_O            = hready_r;
    assign HRESP_O                = hresp_r;
    assign CLK_SEL_EXT_O          = ext_sel;
    assign RESULT_VALID_O         = res_valid;
    assign RESULT_O               = res_data;
    assign REF_ON_O               = ref_on_o_r;
    assign REF_SELECT_O           = ref_sel_r;
    assign EXCITE_A_LEVEL_O       = exc_a_o_r;
    assign EXCITE_B_LEVEL_O       = exc_b_o_r;
    assign EXCITE_A_ROUTE_O       = exc_a_rt_r;
    assign EXCITE_B_ROUTE_O       = exc_b_rt_r;
    assign BURNOUT_ON_O           = burn_on_r;
    assign BURNOUT_LEVEL_O        = burn_r;
    assign BIAS_EN_O              = bias_r;
    assign MUX_POS_O              = mux_pos_r;
    assign MUX_NEG_O              = mux_neg_r;
    assign MONITOR_SEL_O          = mon_r;
    assign ANALOG_CONNECT_O       = analog_conn_r;
    assign ATTEN_QUARTER_O        = atten_r;
    assign INPUT_AMPLIFIER_GAIN_O = amp_gain_r;
    assign GPIO_O                 = gpio_o_r;
    assign GPIO_OE_O              = gpio_oe_r;
    assign ANALOG_PIN_EN_O        = ana_en_r;
endmodule // adc_output_calibration

// File: tb/adc_cal_monitor.sv
// Concurrent pin checks for the converter calibration back end
`timescale 1ns/1ps
`include "adc_cal_consts.vh"
module adc_cal_monitor (
    input wire logic       REF_CLK_I,
    input wire logic       NRST_I,
    input wire logic       EXT_CLK_PIN_I,
    input wire logic       CLK_SEL_EXT_O,
    input wire logic       FILT_VALID_I,
    input wire logic       RESULT_VALID_O,
    input wire logic       REF_ON_O,
    input wire logic [2:0] EXCITE_A_LEVEL_O,
    input wire logic [2:0] EXCITE_B_LEVEL_O,
    input wire logic [2:0] MONITOR_SEL_O,
    input wire logic       ANALOG_CONNECT_O,
    input wire logic       ATTEN_QUARTER_O,
    input wire logic [2:0] INPUT_AMPLIFIER_GAIN_O,
    input wire logic [7:0] GPIO_OE_O,
    input wire logic [7:0] ANALOG_PIN_EN_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);

    AST_RESET_STATE: assert property ($rose(NRST_I) |-> !CLK_SEL_EXT_O && !REF_ON_O)
        else $error("clock select or reference not cleared by reset");
    AST_CLK_SWITCH: assert property ($changed(EXT_CLK_PIN_I) |-> ##[1:3] CLK_SEL_EXT_O)
        else $error("external clock activity not latched");
    AST_CLK_HOLD: assert property (CLK_SEL_EXT_O |=> CLK_SEL_EXT_O)
        else $error("external clock selection dropped without reset");
    AST_EXCITE_GATED: assert property (!REF_ON_O
        |-> (EXCITE_A_LEVEL_O | EXCITE_B_LEVEL_O) == 3'h0)
        else $error("excitation active while reference off");
    // Pin drives may lag the monitor field by a clock, so judge only once it settles
    AST_MON_DISCONNECT: assert property ($stable(MONITOR_SEL_O)
        |-> ANALOG_CONNECT_O == (MONITOR_SEL_O == `MON_NONE))
        else $error("analog inputs connected during monitoring");
    AST_MON_QUARTER: assert property ($stable(MONITOR_SEL_O)
        |-> ATTEN_QUARTER_O == (MONITOR_SEL_O inside {`MON_AVDD, `MON_DVDD, `MON_EXTREF}))
        else $error("quarter attenuation wrong for monitor source");
    AST_TEMP_UNITY: assert property ($stable(MONITOR_SEL_O) && MONITOR_SEL_O == `MON_TEMP
        |-> INPUT_AMPLIFIER_GAIN_O == `GAIN_UNITY)
        else $error("gain not forced to unity for temperature");
    AST_RESULT_PULSE: assert property (FILT_VALID_I |=> RESULT_VALID_O)
        else $error("filter result not answered next cycle");
    AST_RESULT_CAUSE: assert property (RESULT_VALID_O |-> $past(FILT_VALID_I))
        else $error("result strobe without filter input");
    AST_PIN_EXCLUSIVE: assert property ($stable(GPIO_OE_O) && $stable(ANALOG_PIN_EN_O)
        |-> (GPIO_OE_O & ANALOG_PIN_EN_O) == 8'h00)
        else $error("pin driven digitally while analog");

    COV_EXT: cover property ($rose(CLK_SEL_EXT_O));
    COV_RESULT: cover property (RESULT_VALID_O);
    COV_TEMP: cover property (MONITOR_SEL_O == `MON_TEMP);
    COV_EXCITE: cover property (REF_ON_O && EXCITE_A_LEVEL_O == 3'h7);
endmodule // adc_cal_monitor

bind adc_output_calibration adc_cal_monitor adc_cal_monitor_i (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .EXT_CLK_PIN_I(EXT_CLK_PIN_I),
    .CLK_SEL_EXT_O(CLK_SEL_EXT_O), .FILT_VALID_I(FILT_VALID_I),
    .RESULT_VALID_O(RESULT_VALID_O), .REF_ON_O(REF_ON_O),
    .EXCITE_A_LEVEL_O(EXCITE_A_LEVEL_O), .EXCITE_B_LEVEL_O(EXCITE_B_LEVEL_O),
    .MONITOR_SEL_O(MONITOR_SEL_O), .ANALOG_CONNECT_O(ANALOG_CONNECT_O),
    .ATTEN_QUARTER_O(ATTEN_QUARTER_O), .INPUT_AMPLIFIER_GAIN_O(INPUT_AMPLIFIER_GAIN_O),
    .GPIO_OE_O(GPIO_OE_O), .ANALOG_PIN_EN_O(ANALOG_PIN_EN_O)
);

// File: tb/host_bus_model.sv
// Host controller model: AHB-Lite master doing single word transfers
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'b00;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
    end

    // Waits are open ended on purpose; the bench watchdog cuts a hang
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge clk_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= 2'b10;
        hwrite_o <= wr;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        hsel_o <= 1'b0;
        htrans_o <= 2'b00;
        hwdata_o <= wd;
        do @(posedge clk_i); while (hready_i !== 1'b1);
        rd = hrdata_i;
    endtask
endmodule // host_bus_model

// File: tb/tb_top.sv
// Self-checking bench for the converter calibration back end
`timescale 1ns/1ps
`include "adc_cal_consts.vh"
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        ext_pin = 1'b0;
    logic        fv = 1'b0;
    logic [23:0] fd = 24'h000000;
    logic        cdone = 1'b0;
    logic        ctgt = 1'b0;
    logic [23:0] cval = 24'h000000;
    logic [7:0]  gpi = 8'h3c;
    logic [23:0] ofs_m = `OFS_RESET;
    logic [23:0] gc_m = `GC_RESET;
    logic [31:0] rdat;
    logic [71:0] dp [7] = '{{24'h123456, 24'h000000, 24'h400000},
        {24'h000000, 24'h000001, 24'h400000}, {24'h000000, 24'h7fffff, 24'h400000},
        {24'h000000, 24'h800000, 24'h400000}, {24'h300000, 24'h100000, 24'h200000},
        {24'h7fffff, 24'h100000, 24'h800000}, {24'h800000, 24'h100000, 24'h800000}};
    int          errors = 0;
    int          samples_checked = 0;
    wire  [31:0] haddr, hwdata, hrdata;
    wire  [23:0] res;
    wire  [7:0]  bias, gpo, gpoe, pin_en;
    wire  [3:0]  ra, rb;
    wire  [2:0]  hsize, exa, exb, mon, gain, mpos, mneg;
    wire  [1:0]  htrans, rsel, bo_lvl;
    wire         hsel, hwrite, hready, hresp, rvalid, sel_ext, ref_on, bo_on, conn, atten;

    initial
    begin
        forever #4 clk = ~clk;
    end

    host_bus_model host_bus_model_i (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata),
        .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));

    adc_output_calibration adc_output_calibration_i (.REF_CLK_I(clk), .NRST_I(nrst),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .EXT_CLK_PIN_I(ext_pin), .CLK_SEL_EXT_O(sel_ext),
        .FILT_VALID_I(fv), .FILT_DATA_I(fd), .CAL_DONE_I(cdone), .CAL_TARGET_I(ctgt),
        .CAL_VALUE_I(cval), .RESULT_VALID_O(rvalid), .RESULT_O(res), .REF_ON_O(ref_on),
        .REF_SELECT_O(rsel), .EXCITE_A_LEVEL_O(exa), .EXCITE_B_LEVEL_O(exb),
        .EXCITE_A_ROUTE_O(ra), .EXCITE_B_ROUTE_O(rb), .BURNOUT_ON_O(bo_on),
        .BURNOUT_LEVEL_O(bo_lvl), .BIAS_EN_O(bias), .MUX_POS_O(mpos), .MUX_NEG_O(mneg),
        .MONITOR_SEL_O(mon), .ANALOG_CONNECT_O(conn), .ATTEN_QUARTER_O(atten),
        .INPUT_AMPLIFIER_GAIN_O(gain), .GPIO_I(gpi), .GPIO_O(gpo), .GPIO_OE_O(gpoe),
        .ANALOG_PIN_EN_O(pin_en));

    task automatic finish_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Pin drives follow a write one edge after the data phase
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host_bus_model_i.xfer(1'b1, a, d, rdat);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        host_bus_model_i.xfer(1'b0, a, 32'h0, rdat);
        chk(rdat, exp);
    endtask

    task automatic setc(input logic g, input logic [23:0] v);
        for (int i = 0; i < 3; i++)
            wr((g ? `A_GC0 : `A_OFS0) + 8'(4 * i), {24'h0, v[8*i +: 8]});
        if (g)
            gc_m = v;
        else
            ofs_m = v;
    endtask

    function automatic logic [23:0] calc(input logic [23:0] d);
        logic signed [25:0] s;
        logic signed [51:0] p;
        s = $signed({{2{d[23]}}, d}) - $signed({{2{ofs_m[23]}}, ofs_m});
        p = (s * $signed({2'b00, gc_m})) >>> `GC_SHIFT;
        if (p > 8388607)
            return 24'h7fffff;
        if (p < -8388608)
            return 24'h800000;
        return p[23:0];
    endfunction

    task automatic run(input logic [23:0] d);
        @(posedge clk);
        fv <= 1'b1;
        fd <= d;
        @(posedge clk);
        fv <= 1'b0;
        #1;
        chk(32'(rvalid), 32'h1);
        chk(32'(res), 32'(calc(d)));
    endtask

    initial
    begin
        #200000;
        errors++;
        finish_test();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 3; i++)
            rchk(`A_OFS0 + 8'(4 * i), 32'h0);
        rchk(`A_GC2, 32'h40);
        rchk(8'h7c, 32'h0);
        chk(32'(hresp), 32'h0);
        chk(32'(ref_on), 32'h0);
        wr(`A_EXCITE, 32'h9877);
        chk(32'({exa, exb}), 32'h0);
        wr(`A_REF_CTRL, 32'h3);
        chk(32'({ref_on, rsel}), 32'h5);
        for (int i = 1; i < 10; i++)
        begin
            wr(`A_EXCITE, {16'h0, 4'(i), 4'(i), 1'b0, 3'(i % 8), 1'b0, 3'(i % 8)});
            chk(32'({exa, exb, ra, rb}), 32'({3'(i % 8), 3'(i % 8), 4'(i), 4'(i)}));
        end
        wr(`A_EXCITE, 32'h9811);
        chk(32'({ra, rb}), 32'h89);
        for (int i = 1; i < 4; i++)
        begin
            wr(`A_BURNOUT, 32'(i));
            chk(32'({bo_on, bo_lvl}), 32'(4 + i));
        end
        wr(`A_BIAS, 32'ha5);
        chk(32'(bias), 32'ha5);
        wr(`A_GAIN, 32'h5);
        for (int m = 0; m < 5; m++)
        begin
            wr(`A_MUX, 32'((m << 8) | 32'h0a));
            chk(32'({mpos, mneg}), 32'h11);
            chk(32'({mon, conn, atten}), 32'({3'(m), m == 0, m > 1}));
            chk(32'(gain), (m == 1) ? 32'h0 : 32'h5);
        end
        wr(`A_GPIO_CFG, 32'hf0);
        wr(`A_GPIO_DIR, 32'h3c);
        wr(`A_GPIO_DATA, 32'hff);
        chk(32'({gpo, gpoe, pin_en}), 32'hf0300f);
        rchk(`A_GPIO_DATA, 32'h3c);
        for (int i = 0; i < 7; i++)
        begin
            setc(1'b0, dp[i][47:24]);
            setc(1'b1, dp[i][23:0]);
            rchk(`A_OFS2, {24'h0, dp[i][47:40]});
            run(dp[i][71:48]);
        end
        for (int t = 0; t < 2; t++)
        begin
            if (t == 0)
                ofs_m = 24'hfffff0;
            else
                gc_m = 24'h600000;
            @(posedge clk);
            cdone <= 1'b1;
            ctgt <= t[0];
            cval <= (t == 0) ? ofs_m : gc_m;
            @(posedge clk);
            cdone <= 1'b0;
            rchk((t == 0) ? `A_OFS2 : `A_GC2, (t == 0) ? 32'hff : 32'h60);
            run(24'h000100);
        end
        chk(32'(sel_ext), 32'h0);
        repeat (4) @(posedge clk) ext_pin <= ~ext_pin;
        repeat (4) @(posedge clk);
        #1;
        chk(32'(sel_ext), 32'h1);
        repeat (20) @(posedge clk);
        #1;
        chk(32'(sel_ext), 32'h1);
        rchk(`A_STATUS, 32'h3);
        rchk(`A_RESULT, {8'h0, calc(24'h000100)});
        rchk(`A_STATUS, 32'h1);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk(32'({sel_ext, ref_on}), 32'h0);
        rchk(`A_OFS0, 32'h0);
        finish_test();
    end
endmodule // tb_top
